// ### inc/rqsb_params.svh
// Constants for the request sideband upper fields: bit positions, sizes, offsets.
// Assumes inclusion by bare name from both ends, the checker and the bench.
`ifndef RQSB_PARAMS_SVH
`define RQSB_PARAMS_SVH
`define RQSB_DATA_W 256
`define RQSB_BYTES 32
`define RQSB_USER_W 85
`define RQSB_TAG_LO_MSB 27
`define RQSB_TAG_LO_LSB 24
`define RQSB_PAR_MSB 59
`define RQSB_PAR_LSB 28
`define RQSB_TAG_HI_MSB 61
`define RQSB_TAG_HI_LSB 60
`define RQSB_PFX_VLD 62
`define RQSB_PASID_MSB 82
`define RQSB_PASID_LSB 63
`define RQSB_PFX_EXE 83
`define RQSB_PFX_PRIV 84
`define RQSB_LANES_64 8
`define RQSB_LANES_128 16
`define RQSB_PKT_DEPTH 8
`define RQSB_OFS_CTRL 12'h000
`define RQSB_OFS_TAG 12'h004
`define RQSB_OFS_PFX 12'h008
`define RQSB_OFS_SEED 12'h00C
`define RQSB_OFS_LEN 12'h010
`define RQSB_OFS_STAT 12'h014
`define RQSB_OFS_INT_STAT 12'h018
`define RQSB_OFS_INT_MASK 12'h01C
`define RQSB_CTRL_GO 0
`define RQSB_CTRL_PAR_EN 1
`define RQSB_CTRL_TAG_EN 2
`define RQSB_CTRL_INJ 3
`define RQSB_INT_SENT 0
`define RQSB_INT_ECHO 1
`define RQSB_RST_CTRL 4'h2
`endif

// ### inc/rqsb_pkg.sv
// Types shared by both ends of the request sideband link.
// Assumes rqsb_params.svh on the include path.
package rqsb_pkg;
  typedef enum logic [1:0] {RQSB_W64, RQSB_W128, RQSB_W256} rqsb_width_e;
  typedef struct packed {
    logic priv;
    logic exe;
    logic [19:0] pasid;
    logic vld;
  } rqsb_prefix_s;
endpackage

// ### inc/rqsb_if.sv
// Request stream with sideband word and tracking-tag echo between user and device.
// Assumes one shared clock; both ends drive only their own modport outputs.
`timescale 1ns/1ps
interface rqsb_if;
  logic [255:0] request_stream_data;
  logic [84:0] request_sideband_word;
  logic request_stream_valid;
  logic request_stream_ready;
  logic request_stream_last;
  logic [5:0] tracking_tag_echo_out;
  logic tracking_tag_echo_vld;
  modport dev (
    input request_stream_data, request_sideband_word, request_stream_valid,
    input request_stream_last,
    output request_stream_ready, tracking_tag_echo_out, tracking_tag_echo_vld
  );
  modport usr (
    output request_stream_data, request_sideband_word, request_stream_valid,
    output request_stream_last,
    input request_stream_ready, tracking_tag_echo_out, tracking_tag_echo_vld
  );
endinterface

// ### logic/rqsb_dev.sv
// Device end: takes request packets, checks byte parity, holds each packet
// whole, then forwards it to the link pipeline or drops it.
// Assumes the user end keeps the stream stable while valid and not ready.
`timescale 1ns/1ps
`include "rqsb_params.svh"
module rqsb_dev (
  input wire logic i_sys_clk,                      // System clock, 20 MHz
  input wire logic i_arst_n,                       // Async reset, active low
  rqsb_if.dev rq,                                  // Request stream from user
  input wire logic i_par_chk_en,                   // Parity checking enable
  input wire rqsb_pkg::rqsb_width_e i_width,       // Configured data width
  input wire logic i_link_ready,                   // Link pipeline accepts beat
  output logic o_link_valid,                       // Beat offered to link
  output logic [255:0] o_link_data,                // Beat data
  output logic o_link_last,                        // Final beat of packet
  output logic [5:0] o_link_tag,                   // Tag of packet in flight
  output rqsb_pkg::rqsb_prefix_s o_link_prefix,    // Prefix, zero when absent
  output logic o_uncorr_err,                       // Sticky internal error
  output logic o_drop_pulse                        // One pulse per dropped packet
);
  import rqsb_pkg::*;

  typedef enum logic {ST_COLLECT, ST_SEND} rqsb_state_e;

  localparam logic [3:0] DEPTH = 4'(`RQSB_PKT_DEPTH);

  rqsb_state_e state_reg;
  rqsb_state_e state_next;
  logic [255:0] pkt_mem [0:`RQSB_PKT_DEPTH-1];
  logic [3:0] wr_ptr_reg;
  logic [3:0] wr_ptr_next;
  logic [3:0] rd_ptr_reg;
  logic [3:0] rd_ptr_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic first_reg;
  logic first_next;
  logic bad_reg;
  logic bad_next;
  logic [5:0] tag_reg;
  logic [5:0] tag_next;
  rqsb_prefix_s pfx_reg;
  rqsb_prefix_s pfx_next;
  logic err_reg;
  logic err_next;
  logic drop_reg;
  logic drop_next;
  logic [5:0] echo_reg;
  logic [5:0] echo_next;
  logic echo_vld_reg;
  logic echo_vld_next;

  wire beat = rq.request_stream_valid & rq.request_stream_ready;
  wire [84:0] sb = rq.request_sideband_word;
  wire [31:0] par_in = sb[`RQSB_PAR_MSB:`RQSB_PAR_LSB];
  wire [31:0] byte_bad;
  wire [31:0] lane_mask;
  wire par_err;
  wire ovf;
  wire pkt_bad;
  wire send_beat;
  wire send_done;
  wire [5:0] tag_in;
  rqsb_prefix_s pfx_in;

  // Odd parity: a byte plus its parity bit holds an odd count of ones
  genvar gi;
  generate
    for (gi = 0; gi < `RQSB_BYTES; gi++) begin : g_par
      assign byte_bad[gi] = ~^{rq.request_stream_data[8*gi +: 8], par_in[gi]};
    end
  endgenerate

  // Lanes above the configured width are ignored
  assign lane_mask = (i_width == RQSB_W64) ? 32'h000000FF :
                     (i_width == RQSB_W128) ? 32'h0000FFFF : 32'hFFFFFFFF;
  assign par_err = beat & i_par_chk_en & (|(byte_bad & lane_mask));

  // Six-bit tag from two split fields
  assign tag_in = {sb[`RQSB_TAG_HI_MSB:`RQSB_TAG_HI_LSB],
                   sb[`RQSB_TAG_LO_MSB:`RQSB_TAG_LO_LSB]};

  // Prefix fields only kept when flagged valid
  assign pfx_in = sb[`RQSB_PFX_VLD] ?
                  {sb[`RQSB_PFX_PRIV], sb[`RQSB_PFX_EXE],
                   sb[`RQSB_PASID_MSB:`RQSB_PASID_LSB], 1'b1} :
                  23'h0;

  // Packets longer than the holding buffer cannot be replayed; they are dropped
  assign ovf = beat & (wr_ptr_reg == DEPTH);
  assign pkt_bad = bad_reg | par_err | ovf;

  assign send_beat = (state_reg == ST_SEND) & i_link_ready;
  assign send_done = send_beat & o_link_last;

  assign rq.request_stream_ready = (state_reg == ST_COLLECT);
  assign rq.tracking_tag_echo_out = echo_reg;
  assign rq.tracking_tag_echo_vld = echo_vld_reg;

  assign o_link_valid = (state_reg == ST_SEND);
  assign o_link_data = pkt_mem[rd_ptr_reg[2:0]];
  assign o_link_last = (state_reg == ST_SEND) & (rd_ptr_reg == cnt_reg - 4'h1);
  assign o_link_tag = tag_reg;
  assign o_link_prefix = pfx_reg;
  assign o_uncorr_err = err_reg;
  assign o_drop_pulse = drop_reg;

  always_comb begin
    state_next = state_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    cnt_next = cnt_reg;
    first_next = first_reg;
    bad_next = bad_reg;
    tag_next = tag_reg;
    pfx_next = pfx_reg;
    drop_next = 1'b0;
    echo_next = echo_reg;
    echo_vld_next = 1'b0;
    // Recorded as uncorrectable; only reset clears it
    err_next = err_reg | par_err;
    case (state_reg)
      ST_COLLECT: begin
        if (beat) begin
          first_next = rq.request_stream_last;
          if (first_reg) begin
            tag_next = tag_in;
            pfx_next = pfx_in;
          end
          if (!ovf) begin
            wr_ptr_next = wr_ptr_reg + 4'h1;
          end
          bad_next = pkt_bad;
          if (rq.request_stream_last) begin
            wr_ptr_next = 4'h0;
            bad_next = 1'b0;
            if (pkt_bad) begin
              drop_next = 1'b1;
            end else begin
              cnt_next = wr_ptr_reg + 4'h1;
              rd_ptr_next = 4'h0;
              state_next = ST_SEND;
            end
          end
        end
      end
      ST_SEND: begin
        if (send_beat) begin
          rd_ptr_next = rd_ptr_reg + 4'h1;
        end
        // Past the link handoff no completion can overtake it
        if (send_done) begin
          echo_next = tag_reg;
          echo_vld_next = 1'b1;
          state_next = ST_COLLECT;
        end
      end
      default: begin
        state_next = ST_COLLECT;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= ST_COLLECT;
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      cnt_reg <= 4'h0;
      first_reg <= 1'b1;
      bad_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg <= cnt_next;
      first_reg <= first_next;
      bad_reg <= bad_next;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tag_reg <= 6'h00;
      pfx_reg <= '0;
      err_reg <= 1'b0;
      drop_reg <= 1'b0;
      echo_reg <= 6'h00;
      echo_vld_reg <= 1'b0;
    end else begin
      tag_reg <= tag_next;
      pfx_reg <= pfx_next;
      err_reg <= err_next;
      drop_reg <= drop_next;
      echo_reg <= echo_next;
      echo_vld_reg <= echo_vld_next;
    end
  end

  // Buffer holds data only; no reset needed on the array
  always_ff @(posedge i_sys_clk) begin
    if (beat && !ovf) begin
      pkt_mem[wr_ptr_reg[2:0]] <= rq.request_stream_data;
    end
  end
endmodule

// ### logic/rqsb_usr.sv
// User end: APB-programmed request source driving the stream and sideband.
// Assumes an APB master on the same clock; answers after one wait state.
`timescale 1ns/1ps
`include "rqsb_params.svh"
module rqsb_usr (
  input wire logic i_sys_clk,          // System clock, 20 MHz
  input wire logic i_arst_n,           // Async reset, active low
  rqsb_if.usr rq,                      // Request stream toward device
  input wire logic i_psel,             // APB select
  input wire logic i_penable,          // APB access phase
  input wire logic i_pwrite,           // APB direction
  input wire logic [11:0] i_paddr,     // APB byte address
  input wire logic [31:0] i_pwdata,    // APB write data
  output logic [31:0] o_prdata,        // APB read data
  output logic o_pready,               // APB ready
  output logic o_pslverr,              // APB error on unmapped address
  output logic o_irq                   // Level interrupt
);
  import rqsb_pkg::*;

  typedef enum logic {SU_IDLE, SU_SEND} rqsb_ustate_e;

  rqsb_ustate_e state_reg;
  logic [3:0] ctrl_reg;
  logic [5:0] tag_reg;
  rqsb_prefix_s pfx_reg;
  logic [31:0] seed_reg;
  logic [3:0] len_reg;
  logic [3:0] beat_reg;
  logic [5:0] echo_reg;
  logic [1:0] int_stat_reg;
  logic [1:0] int_mask_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic err_reg;

  wire acc = i_psel & i_penable & ~ack_reg;
  wire wr = i_psel & i_penable & ack_reg & i_pwrite;
  wire a_ctrl = (i_paddr == `RQSB_OFS_CTRL);
  wire a_tag = (i_paddr == `RQSB_OFS_TAG);
  wire a_pfx = (i_paddr == `RQSB_OFS_PFX);
  wire a_seed = (i_paddr == `RQSB_OFS_SEED);
  wire a_len = (i_paddr == `RQSB_OFS_LEN);
  wire a_stat = (i_paddr == `RQSB_OFS_STAT);
  wire a_ist = (i_paddr == `RQSB_OFS_INT_STAT);
  wire a_imsk = (i_paddr == `RQSB_OFS_INT_MASK);
  wire mapped = a_ctrl | a_tag | a_pfx | a_seed | a_len | a_stat | a_ist | a_imsk;
  wire go = wr & a_ctrl & i_pwdata[`RQSB_CTRL_GO] & (state_reg == SU_IDLE);
  wire beat = rq.request_stream_valid & rq.request_stream_ready;
  wire last = (beat_reg == len_reg - 4'h1) | (len_reg == 4'h0);
  wire done = beat & last;
  wire [31:0] word = seed_reg + {28'h0000000, beat_reg};
  wire [31:0] par;
  wire [5:0] tag_out;
  wire [31:0] rsel;

  // Odd parity per byte, zero when checking is off
  genvar gi;
  generate
    for (gi = 0; gi < `RQSB_BYTES; gi++) begin : g_par
      assign par[gi] = ctrl_reg[`RQSB_CTRL_PAR_EN] &
                       (~^rq.request_stream_data[8*gi +: 8] ^
                        ((gi == 0) & ctrl_reg[`RQSB_CTRL_INJ]));
    end
  endgenerate

  // Tag held at zero when the echo is not watched
  assign tag_out = ctrl_reg[`RQSB_CTRL_TAG_EN] ? tag_reg : 6'h00;

  assign rq.request_stream_valid = (state_reg == SU_SEND);
  assign rq.request_stream_last = (state_reg == SU_SEND) & last;
  assign rq.request_stream_data = {8{word}};
  // Bits 23:0 below the tag stay zero; the full word is 85 bits
  assign rq.request_sideband_word = {pfx_reg.priv, pfx_reg.exe, pfx_reg.pasid,
                                     pfx_reg.vld, tag_out[5:4], par, tag_out[3:0],
                                     24'h000000};

  assign rsel = a_ctrl ? {28'h0000000, ctrl_reg & 4'hE} :
                a_tag ? {26'h0000000, tag_reg} :
                a_pfx ? {9'h000, pfx_reg} :
                a_seed ? seed_reg :
                a_len ? {28'h0000000, len_reg} :
                a_stat ? {18'h00000, echo_reg, 7'h00, (state_reg == SU_SEND)} :
                a_ist ? {30'h00000000, int_stat_reg} :
                a_imsk ? {30'h00000000, int_mask_reg} : 32'h00000000;

  assign o_pready = ack_reg;
  assign o_prdata = rdata_reg;
  assign o_pslverr = ack_reg & err_reg;
  assign o_irq = |(int_stat_reg & int_mask_reg);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= acc;
      err_reg <= acc & ~mapped;
      if (acc) begin
        rdata_reg <= rsel;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reg <= `RQSB_RST_CTRL;
      tag_reg <= 6'h00;
      pfx_reg <= '0;
      seed_reg <= 32'h00000000;
      len_reg <= 4'h1;
      int_mask_reg <= 2'h0;
    end else if (wr) begin
      if (a_ctrl) ctrl_reg <= {i_pwdata[3:1], 1'b0};
      if (a_tag) tag_reg <= i_pwdata[5:0];
      if (a_pfx) pfx_reg <= i_pwdata[22:0];
      if (a_seed) seed_reg <= i_pwdata;
      if (a_len) len_reg <= i_pwdata[3:0];
      if (a_imsk) int_mask_reg <= i_pwdata[1:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= SU_IDLE;
      beat_reg <= 4'h0;
      echo_reg <= 6'h00;
      int_stat_reg <= 2'h0;
    end else begin
      if (go) begin
        state_reg <= SU_SEND;
        beat_reg <= 4'h0;
      end else if (done) begin
        state_reg <= SU_IDLE;
      end else if (beat) begin
        beat_reg <= beat_reg + 4'h1;
      end
      if (rq.tracking_tag_echo_vld) begin
        echo_reg <= rq.tracking_tag_echo_out;
      end
      // New events win over a same-cycle write-one clear
      int_stat_reg <= (int_stat_reg & ~((wr & a_ist) ? i_pwdata[1:0] : 2'h0)) |
                      {rq.tracking_tag_echo_vld, done};
    end
  end
endmodule

// ### verification/rqsb_props.sv
// Checker for the request stream between the user and device ends.
// Assumes one clock domain; tb_top wires it beside the interface.
`timescale 1ns/1ps
`include "rqsb_params.svh"
module rqsb_props (
  input wire logic i_sys_clk,                     // Clock
  input wire logic i_arst_n,                      // Async reset, active low
  input wire logic [255:0] request_stream_data,   // Beat data
  input wire logic [84:0] request_sideband_word,  // Sideband word
  input wire logic request_stream_valid,          // Beat offered
  input wire logic request_stream_ready,          // Device collecting
  input wire logic request_stream_last,           // Final beat
  input wire logic [5:0] tracking_tag_echo_out,   // Echoed tag
  input wire logic tracking_tag_echo_vld,         // Echo pulse
  input wire logic i_par_chk_en,                  // Parity check enable
  input wire rqsb_pkg::rqsb_width_e i_width,      // Data width
  input wire logic i_link_ready,                  // Link takes beat
  input wire logic o_link_valid,                  // Beat to link
  input wire logic o_link_last,                   // Last beat to link
  input wire logic [5:0] o_link_tag,              // Tag in flight
  input wire rqsb_pkg::rqsb_prefix_s o_link_prefix, // Prefix in flight
  input wire logic o_uncorr_err,                  // Sticky error
  input wire logic o_drop_pulse                   // Drop pulse
);
  import rqsb_pkg::*;
  logic [31:0] lane_odd;
  logic first_reg;
  logic pkt_bad_reg;
  logic [5:0] tag_reg;
  rqsb_prefix_s pfx_reg;
  wire [84:0] sb = request_sideband_word;
  wire [31:0] lane_mask = (i_width == RQSB_W64) ? 32'h0000_00FF :
    (i_width == RQSB_W128) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
  wire beat_acc = request_stream_valid & request_stream_ready;
  wire beat_bad = i_par_chk_en & (|(~lane_odd & lane_mask));
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      lane_odd[i] = ^{request_stream_data[8*i +: 8], sb[`RQSB_PAR_LSB + i]};
    end
  end
  // Expected tag and prefix, latched on the first beat only
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      first_reg <= 1'b1;
      pkt_bad_reg <= 1'b0;
      tag_reg <= 6'h00;
      pfx_reg <= '0;
    end else if (beat_acc) begin
      first_reg <= request_stream_last;
      pkt_bad_reg <= (pkt_bad_reg | beat_bad) & !request_stream_last;
      if (first_reg) begin
        tag_reg <= {sb[61:60], sb[27:24]};
        pfx_reg <= sb[`RQSB_PFX_VLD] ? {sb[84], sb[83], sb[82:63], 1'b1} : 23'h0;
      end
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence s_link_end;
    o_link_valid && i_link_ready && o_link_last;
  endsequence
  sequence s_bad_end;
    beat_acc && request_stream_last && (pkt_bad_reg || beat_bad);
  endsequence
  a_err_on_parity: assert property (
    beat_acc && beat_bad |=> o_uncorr_err)
    else $error("parity mismatch not recorded");
  a_err_no_cause: assert property (
    !o_uncorr_err && !(beat_acc && beat_bad) |=> !o_uncorr_err)
    else $error("error flag set without a checked mismatch");
  a_err_stays_set: assert property (!$fell(o_uncorr_err))
    else $error("error flag cleared without reset");
  a_drop_bad_pkt: assert property (s_bad_end |=> o_drop_pulse ##1 !o_drop_pulse)
    else $error("bad packet not dropped with one pulse");
  a_drop_not_sent: assert property (s_bad_end |=> !o_link_valid)
    else $error("bad packet offered to link");
  a_echo_tag_value: assert property (
    s_link_end |=> tracking_tag_echo_vld && tracking_tag_echo_out == $past(o_link_tag))
    else $error("echo missing or wrong after last link beat");
  a_echo_only_after: assert property (
    tracking_tag_echo_vld |-> $past(o_link_valid && i_link_ready && o_link_last))
    else $error("echo without a finished link packet");
  a_link_tag_first: assert property (o_link_valid |-> o_link_tag == tag_reg)
    else $error("link tag differs from first beat tag");
  a_link_prefix: assert property (
    o_link_valid |-> o_link_prefix == pfx_reg)
    else $error("link prefix differs from first beat fields");
endmodule

// ### verification/tb_top.sv
// Self-checking bench: APB-driven user end feeding the device end.
// Assumes both ends share one 20 MHz clock and one async reset.
`timescale 1ns/1ps
`include "rqsb_params.svh"
module tb_top;
  import rqsb_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic par_en = 1'b1;
  logic link_ready = 1'b1;
  rqsb_width_e width = RQSB_W256;
  logic [31:0] prdata;
  logic pready, pslverr, irq, link_valid, link_last, uncorr_err, drop_pulse, new_pkt;
  logic [255:0] link_data, last_data;
  logic [5:0] link_tag;
  rqsb_prefix_s link_prefix, last_pfx;
  int errors = 0;
  int check_count = 0;
  int beats = 0;
  int drops = 0;
  int echoes = 0;
  rqsb_if rq_bus();
  rqsb_usr u_rqsb_usr (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .rq(rq_bus), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq));
  rqsb_dev u_rqsb_dev (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .rq(rq_bus),
    .i_par_chk_en(par_en), .i_width(width), .i_link_ready(link_ready),
    .o_link_valid(link_valid), .o_link_data(link_data), .o_link_last(link_last),
    .o_link_tag(link_tag), .o_link_prefix(link_prefix), .o_uncorr_err(uncorr_err),
    .o_drop_pulse(drop_pulse));
  rqsb_props chk_link (.i_sys_clk(sys_clk), .i_arst_n(arst_n),
    .request_stream_data(rq_bus.request_stream_data),
    .request_sideband_word(rq_bus.request_sideband_word),
    .request_stream_valid(rq_bus.request_stream_valid),
    .request_stream_ready(rq_bus.request_stream_ready),
    .request_stream_last(rq_bus.request_stream_last),
    .tracking_tag_echo_out(rq_bus.tracking_tag_echo_out),
    .tracking_tag_echo_vld(rq_bus.tracking_tag_echo_vld), .i_par_chk_en(par_en),
    .i_width(width), .i_link_ready(link_ready), .o_link_valid(link_valid),
    .o_link_last(link_last), .o_link_tag(link_tag), .o_link_prefix(link_prefix),
    .o_uncorr_err(uncorr_err), .o_drop_pulse(drop_pulse));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  initial new_pkt = 1'b1;
  always @(posedge sys_clk) begin
    if (link_valid === 1'b1 && link_ready === 1'b1) begin
      beats++;
      if (new_pkt) last_pfx = link_prefix;
      new_pkt = link_last;
      last_data = link_data;
    end
    if (drop_pulse === 1'b1) drops++;
    if (rq_bus.tracking_tag_echo_vld === 1'b1) echoes++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Request held until pready is seen high at a rising edge
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic wait_evt(input int target);
    while (drops + echoes < target) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rd(`RQSB_OFS_CTRL, r);
    chk(r, {28'h0, `RQSB_RST_CTRL});
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
  endtask
  task automatic t_good_stall;
    logic [31:0] r;
    link_ready <= 1'b0;
    wr(`RQSB_OFS_TAG, 32'h2D);
    wr(`RQSB_OFS_PFX, 32'h0055_79BD);
    wr(`RQSB_OFS_SEED, 32'h1122_3344);
    wr(`RQSB_OFS_LEN, 32'h3);
    wr(`RQSB_OFS_CTRL, 32'h7);
    repeat (20) @(posedge sys_clk);
    chk(beats, 0);
    link_ready <= 1'b1;
    wait_evt(1);
    chk(beats, 3);
    chk(last_data[255:224], 32'h1122_3346);
    chk({9'h0, last_pfx}, 32'h0055_79BD);
    chk({26'h0, rq_bus.tracking_tag_echo_out}, 32'h2D);
    rd(`RQSB_OFS_STAT, r);
    chk({26'h0, r[13:8]}, 32'h2D);
    rd(`RQSB_OFS_INT_STAT, r);
    chk(r, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(`RQSB_OFS_INT_MASK, 32'h2);
    // Mask lands at the completing edge; look once it has settled
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    wr(`RQSB_OFS_INT_STAT, 32'h2);
    rd(`RQSB_OFS_INT_STAT, r);
    chk(r, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`RQSB_OFS_INT_STAT, 32'h1);
  endtask
  task automatic t_no_prefix;
    // Narrow width, single beat, prefix fields set but flag low
    width <= RQSB_W128;
    wr(`RQSB_OFS_TAG, 32'h3F);
    wr(`RQSB_OFS_PFX, 32'h0060_0002);
    wr(`RQSB_OFS_LEN, 32'h0);
    wr(`RQSB_OFS_CTRL, 32'h7);
    wait_evt(2);
    chk(beats, 4);
    chk({9'h0, last_pfx}, 32'h0);
    chk({26'h0, rq_bus.tracking_tag_echo_out}, 32'h3F);
  endtask
  task automatic t_parity;
    par_en <= 1'b0;
    wr(`RQSB_OFS_CTRL, 32'hF);
    wait_evt(3);
    chk(beats, 5);
    chk({31'h0, uncorr_err}, 32'h0);
    par_en <= 1'b1;
    width <= RQSB_W64;
    wr(`RQSB_OFS_CTRL, 32'hF);
    wait_evt(4);
    chk(drops, 1);
    chk(beats, 5);
    chk(echoes, 3);
    chk({31'h0, uncorr_err}, 32'h1);
    width <= RQSB_W256;
    wr(`RQSB_OFS_PFX, 32'h0020_0003);
    // Tag disabled: the field goes out as zero
    wr(`RQSB_OFS_CTRL, 32'h3);
    wait_evt(5);
    chk(beats, 6);
    chk({26'h0, rq_bus.tracking_tag_echo_out}, 32'h0);
    chk({9'h0, last_pfx}, 32'h0020_0003);
    chk({31'h0, uncorr_err}, 32'h1);
  endtask
  task automatic conclude;
    $display("errors=%0d check_count=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs();
    t_good_stall();
    t_no_prefix();
    t_parity();
    conclude();
  end
  initial begin
    #500000;
    errors++;
    conclude();
  end
endmodule
